/* File: hw/pcx_crossbar.v */
// priority crossbar with port 0/1 latches and pin drivers
`timescale 1ns/100ps
`include "pcx_consts.vh"

// Behaviour
// - top bit routes comparator A output
// - bit 6 routes array count input
// - three-bit field routes 0-5 capture outputs
// - async serial pins assigned only as pair
// - sync serial takes four pins together
// - two-wire bus sits on pins 0,1
// - second register enables eight single pins
// - bit 7 disables pull-ups; push-pull none
// - bit 6 is global routing enable
// - bits 5-1 read zero, ignore writes
// - bit 0 routes converter start input
// - enabled functions fill pins by priority
// - unclaimed port 0/1 pins follow port latch bit; unclaimed port 2 pins stay released
// - port writes held in output latch
// - plain port read returns pin levels
// - read-modify-write reads latch, not pins
// - config bit one push-pull, zero open-drain
// - open-drain high releases the pin
// - two-wire and receive pins forced open-drain
// - ports accessed as bytes or bits
// - routing off keeps all pins input
// - no pull-up on pin driving low
module pcx_crossbar #(
   parameter NF = `PCX_NFUNC,
   parameter NP = `PCX_NPIN,
   parameter SW = `PCX_SLOTW,
   parameter PW = `PCX_PORTW
) (
   input wire clk,
   input wire sys_rst,
   // special-function register bus
   input wire [7:0] sfrAddr,
   input wire sfrWrEn,
   input wire [7:0] sfrWrData,
   input wire sfrBitWrEn,
   input wire [2:0] sfrBitSel,
   input wire sfrBitVal,
   input wire sfrRdEn,
   input wire sfrRmw,
   output reg [7:0] sfrRdData,
   output reg sfrRdHit,
   // peripheral side, one entry per function in priority order
   input wire [NF-1:0] funcOut,
   input wire [NF-1:0] funcOe,
   output reg [NF-1:0] funcIn,
   // pads: port 0 bits 0-7, port 1 bits 8-15, port 2 bits 16-23
   input wire [NP-1:0] pinIn,
   output reg [NP-1:0] pinOut,
   output reg [NP-1:0] pinOe,
   output reg [NP-1:0] pinPullEn
);

   // software-visible registers
   reg [PW-1:0] port0Latch_q; // port 0 output latch
   reg [PW-1:0] port1Latch_q; // port 1 output latch
   reg [PW-1:0] port0Cfg_q; // port 0 drive mode
   reg [PW-1:0] port1Cfg_q; // port 1 drive mode
   reg [7:0] route1_q; // first routing register
   reg [7:0] route2_q; // second routing register
   reg [7:0] route3_q; // third routing register, spare bits 0

   // next values
   reg [PW-1:0] port0Latch_d;
   reg [PW-1:0] port1Latch_d;
   reg [PW-1:0] port0Cfg_d;
   reg [PW-1:0] port1Cfg_d;
   reg [7:0] route1_d;
   reg [7:0] route2_d;
   reg [7:0] route3_d;

   // decoded fields
   wire xbarOn; // global routing enable
   wire pullDis; // global weak pull-up disable
   wire [2:0] capCode; // capture output count field
   wire [2:0] capCnt; // legal count, reserved codes give 0
   wire [NF-1:0] funcEn; // per-function pin request

   // allocator results
   wire [NF*SW-1:0] funcSlot;
   wire [NP-1:0] pinClaim;
   wire [NP*SW-1:0] pinFunc;

   // combinational pad drive, registered below
   wire [NP-1:0] drvVal;
   wire [NP-1:0] drvOe;
   wire [NP-1:0] pullOn;

   // read path
   reg [7:0] rdNext;
   reg rdHitNext;

   // a bit write only touches the selected bit of a byte
   function [7:0] bitMerge;
      input [7:0] old;
      input [2:0] sel;
      input val;
      reg [7:0] tmp;
      begin
         tmp = old;
         tmp[sel] = val;
         bitMerge = tmp;
      end
   endfunction

   // write decode: byte writes and bit writes share one path
   always @* begin
      port0Latch_d = port0Latch_q;
      port1Latch_d = port1Latch_q;
      port0Cfg_d = port0Cfg_q;
      port1Cfg_d = port1Cfg_q;
      route1_d = route1_q;
      route2_d = route2_q;
      route3_d = route3_q;
      if (sfrWrEn) begin
         // whole-byte write
         case (sfrAddr)
            `PCX_ADDR_P0LAT: port0Latch_d = sfrWrData;
            `PCX_ADDR_P1LAT: port1Latch_d = sfrWrData;
            `PCX_ADDR_P0CFG: port0Cfg_d = sfrWrData;
            `PCX_ADDR_P1CFG: port1Cfg_d = sfrWrData;
            `PCX_ADDR_ROUTE1: route1_d = sfrWrData;
            `PCX_ADDR_ROUTE2: route2_d = sfrWrData;
            // spare bits are dropped on the way in
            `PCX_ADDR_ROUTE3: route3_d = sfrWrData & `PCX_R3_MASK;
            default: ;
         endcase
      end else if (sfrBitWrEn) begin
         // single-bit write merges with the latch, never the pins
         case (sfrAddr)
            `PCX_ADDR_P0LAT: begin
               port0Latch_d = bitMerge(port0Latch_q, sfrBitSel,
                                       sfrBitVal);
            end
            `PCX_ADDR_P1LAT: begin
               port1Latch_d = bitMerge(port1Latch_q, sfrBitSel,
                                       sfrBitVal);
            end
            `PCX_ADDR_P0CFG: begin
               port0Cfg_d = bitMerge(port0Cfg_q, sfrBitSel, sfrBitVal);
            end
            `PCX_ADDR_P1CFG: begin
               port1Cfg_d = bitMerge(port1Cfg_q, sfrBitSel, sfrBitVal);
            end
            `PCX_ADDR_ROUTE1: begin
               route1_d = bitMerge(route1_q, sfrBitSel, sfrBitVal);
            end
            `PCX_ADDR_ROUTE2: begin
               route2_d = bitMerge(route2_q, sfrBitSel, sfrBitVal);
            end
            `PCX_ADDR_ROUTE3: begin
               route3_d = bitMerge(route3_q, sfrBitSel, sfrBitVal)
                          & `PCX_R3_MASK;
            end
            default: ;
         endcase
      end
   end

   // register state; latches come up high so pins idle released
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         port0Latch_q <= `PCX_RST_LATCH;
         port1Latch_q <= `PCX_RST_LATCH;
         port0Cfg_q <= `PCX_RST_CFG;
         port1Cfg_q <= `PCX_RST_CFG;
         route1_q <= `PCX_RST_ROUTE;
         route2_q <= `PCX_RST_ROUTE;
         route3_q <= `PCX_RST_ROUTE;
      end else begin
         port0Latch_q <= port0Latch_d;
         port1Latch_q <= port1Latch_d;
         port0Cfg_q <= port0Cfg_d;
         port1Cfg_q <= port1Cfg_d;
         route1_q <= route1_d;
         route2_q <= route2_d;
         route3_q <= route3_d;
      end
   end

   // global controls from the third routing register
   assign xbarOn = route3_q[`PCX_R3_XBAR];
   assign pullDis = route3_q[`PCX_R3_PUD];

   // reserved capture codes count as zero outputs
   assign capCode = route1_q[`PCX_R1_CAP_HI:`PCX_R1_CAP_LO];
   assign capCnt = (capCode > `PCX_CAP_MAX) ? 3'h0 : capCode;

   // function request vector in priority order; every entry is
   // gated by the global enable so nothing claims a pin while off
   assign funcEn[`PCX_F_SDA] = xbarOn & route1_q[`PCX_R1_TWO_WIRE];
   assign funcEn[`PCX_F_SCL] = xbarOn & route1_q[`PCX_R1_TWO_WIRE];

   // the four sync serial signals share one enable
   generate
      genvar s;
      for (s = `PCX_F_SCK; s < `PCX_F_TX; s = s + 1) begin : gSync
         assign funcEn[s] = xbarOn & route1_q[`PCX_R1_SYNC];
      end
   endgenerate

   // transmit and receive cannot be split
   assign funcEn[`PCX_F_TX] = xbarOn & route1_q[`PCX_R1_ASYNC];
   assign funcEn[`PCX_F_RX] = xbarOn & route1_q[`PCX_R1_ASYNC];

   // capture outputs: module 0 first, as many as the field asks
   generate
      genvar c;
      for (c = 0; c < `PCX_NCAP; c = c + 1) begin : gCap
         assign funcEn[`PCX_F_CAP0+c] = xbarOn
                                        & (capCnt > c);
      end
   endgenerate

   assign funcEn[`PCX_F_CNT_IN] = xbarOn
                                  & route1_q[`PCX_R1_CNT_IN];
   assign funcEn[`PCX_F_CMP_A] = xbarOn
                                 & route1_q[`PCX_R1_CMP_A];

   // second register: bit 0 is comparator B up to bit 7 clock out,
   // which matches the priority order one entry per bit
   generate
      genvar b;
      for (b = 0; b < 8; b = b + 1) begin : gRoute2
         assign funcEn[`PCX_F_CMP_B+b] = xbarOn & route2_q[b];
      end
   endgenerate

   assign funcEn[`PCX_F_CONV] = xbarOn
                                & route3_q[`PCX_R3_CONV];

   // fill pins from port 0 bit 0 upward, skipping unused entries
   pcx_slot_alloc #(
      .NF(NF),
      .NP(NP),
      .SW(SW)
   ) uAlloc (
      .funcEn(funcEn),
      .funcSlot(funcSlot),
      .pinClaim(pinClaim),
      .pinFunc(pinFunc)
   );

   // one driver per pin; port 2 has no latch or mode register here,
   // so its free pins stay released and open-drain
   generate
      genvar n;
      for (n = 0; n < NP; n = n + 1) begin : gPin
         wire [SW-1:0] fIdx; // function on this pin
         wire latchBit; // general-purpose value
         wire pushPull; // drive mode
         wire forceOd; // two-wire or receive on port 0
         assign fIdx = pinFunc[n*SW +: SW];
         if (n < PW) begin : gP0
            assign latchBit = port0Latch_q[n];
            assign pushPull = port0Cfg_q[n];
            // these lines must never be driven high
            assign forceOd = pinClaim[n]
                             & (fIdx == `PCX_F_SDA
                                | fIdx == `PCX_F_SCL
                                | fIdx == `PCX_F_RX);
         end else if (n < 2*PW) begin : gP1
            assign latchBit = port1Latch_q[n-PW];
            assign pushPull = port1Cfg_q[n-PW];
            assign forceOd = 1'b0;
         end else begin : gP2
            assign latchBit = 1'b1;
            assign pushPull = 1'b0;
            assign forceOd = 1'b0;
         end
         pcx_pin_cell uCell (
            .xbarOn(xbarOn),
            .claim(pinClaim[n]),
            .funcOut(funcOut[fIdx]),
            .funcOe(funcOe[fIdx]),
            .latchBit(latchBit),
            .pushPull(pushPull),
            .forceOd(forceOd),
            .pullDis(pullDis),
            .drvVal(drvVal[n]),
            .drvOe(drvOe[n]),
            .pullOn(pullOn[n])
         );
         // pad outputs held in flops; reset leaves pins as inputs
         always @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               pinOut[n] <= 1'b1;
               pinOe[n] <= 1'b0;
               pinPullEn[n] <= 1'b1;
            end else begin
               pinOut[n] <= drvVal[n];
               pinOe[n] <= drvOe[n];
               pinPullEn[n] <= pullOn[n];
            end
         end
      end
   endgenerate

   // peripheral inputs see their pin; unrouted ones idle high
   generate
      genvar g;
      for (g = 0; g < NF; g = g + 1) begin : gFin
         wire [SW-1:0] slot;
         assign slot = funcSlot[g*SW +: SW];
         always @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               funcIn[g] <= 1'b1;
            end else if (funcEn[g]) begin
               funcIn[g] <= pinIn[slot];
            end else begin
               funcIn[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // read mux; a port read gives pin levels unless the core is
   // doing a read-modify-write, which must see the latch instead
   always @* begin
      rdNext = 8'h00;
      rdHitNext = 1'b1;
      case (sfrAddr)
         `PCX_ADDR_P0LAT: begin
            if (sfrRmw) begin
               rdNext = port0Latch_q;
            end else begin
               rdNext = pinIn[PW-1:0];
            end
         end
         `PCX_ADDR_P1LAT: begin
            if (sfrRmw) begin
               rdNext = port1Latch_q;
            end else begin
               rdNext = pinIn[2*PW-1:PW];
            end
         end
         `PCX_ADDR_P0CFG: rdNext = port0Cfg_q;
         `PCX_ADDR_P1CFG: rdNext = port1Cfg_q;
         `PCX_ADDR_ROUTE1: rdNext = route1_q;
         `PCX_ADDR_ROUTE2: rdNext = route2_q;
         // spare bits were never stored, so they read as zero
         `PCX_ADDR_ROUTE3: rdNext = route3_q & `PCX_R3_MASK;
         default: begin
            // not ours: the core takes another block's answer
            rdHitNext = 1'b0;
         end
      endcase
   end

   // read answer one cycle after the strobe, held until next read
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sfrRdData <= 8'h00;
         sfrRdHit <= 1'b0;
      end else if (sfrRdEn) begin
         sfrRdData <= rdNext;
         sfrRdHit <= rdHitNext;
      end
   end

endmodule

/* File: hw/pcx_consts.vh */
// constants for the priority crossbar and port block
`ifndef PCX_CONSTS_VH
`define PCX_CONSTS_VH
// register addresses on the special-function bus
`define PCX_ADDR_P0LAT 8'h80
`define PCX_ADDR_P1LAT 8'h90
`define PCX_ADDR_P0CFG 8'hA4
`define PCX_ADDR_P1CFG 8'hA5
`define PCX_ADDR_ROUTE1 8'hE1
`define PCX_ADDR_ROUTE2 8'hE2
`define PCX_ADDR_ROUTE3 8'hE3
// reset values
`define PCX_RST_LATCH 8'hFF
`define PCX_RST_CFG 8'h00
`define PCX_RST_ROUTE 8'h00
// first routing register fields
`define PCX_R1_CMP_A 7
`define PCX_R1_CNT_IN 6
`define PCX_R1_CAP_HI 5
`define PCX_R1_CAP_LO 3
`define PCX_R1_ASYNC 2
`define PCX_R1_SYNC 1
`define PCX_R1_TWO_WIRE 0
`define PCX_CAP_MAX 3'h5
// third routing register fields
`define PCX_R3_PUD 7
`define PCX_R3_XBAR 6
`define PCX_R3_CONV 0
`define PCX_R3_MASK 8'hC1
// function indices in priority order
`define PCX_F_SDA 0
`define PCX_F_SCL 1
`define PCX_F_SCK 2
`define PCX_F_MOSI 4
`define PCX_F_TX 6
`define PCX_F_RX 7
`define PCX_F_CAP0 8
`define PCX_F_CNT_IN 13
`define PCX_F_CMP_A 14
`define PCX_F_CMP_B 15
`define PCX_F_CONV 23
// counts and widths
`define PCX_NFUNC 24
`define PCX_NPIN 24
`define PCX_SLOTW 5
`define PCX_PORTW 8
`define PCX_NCAP 5
`endif

/* File: hw/pcx_slot_alloc.v */
// priority slot allocator: packs enabled functions onto pins
`timescale 1ns/100ps
`include "pcx_consts.vh"
module pcx_slot_alloc #(
   parameter NF = `PCX_NFUNC,
   parameter NP = `PCX_NPIN,
   parameter SW = `PCX_SLOTW
) (
   input wire [NF-1:0] funcEn,
   output wire [NF*SW-1:0] funcSlot,
   output reg [NP-1:0] pinClaim,
   output reg [NP*SW-1:0] pinFunc
);
   // running count of enabled functions ahead of each entry
   wire [SW-1:0] runCnt [0:NF];
   integer p;
   integer f;
   assign runCnt[0] = {SW{1'b0}};
   genvar k;
   generate
      for (k = 0; k < NF; k = k + 1) begin : gSlot
         // disabled entries take no slot, later ones move up
         assign runCnt[k+1] = runCnt[k] + {{(SW-1){1'b0}}, funcEn[k]};
         assign funcSlot[k*SW +: SW] = runCnt[k];
      end
   endgenerate
   // reverse map: which function sits on each pin
   always @* begin
      pinClaim = {NP{1'b0}};
      pinFunc = {(NP*SW){1'b0}};
      for (p = 0; p < NP; p = p + 1) begin
         for (f = 0; f < NF; f = f + 1) begin
            if (funcEn[f] && runCnt[f] == p[SW-1:0]) begin
               pinClaim[p] = 1'b1;
               pinFunc[p*SW +: SW] = f[SW-1:0];
            end
         end
      end
   end
endmodule

/* File: hw/pcx_pin_cell.v */
// one pin driver: value, enable and weak pull-up
`timescale 1ns/100ps
module pcx_pin_cell (
   input wire xbarOn,
   input wire claim,
   input wire funcOut,
   input wire funcOe,
   input wire latchBit,
   input wire pushPull,
   input wire forceOd,
   input wire pullDis,
   output wire drvVal,
   output wire drvOe,
   output wire pullOn
);
   wire val;
   wire odMode;
   wire released; // claimed by a function that is not driving
   // a peripheral that is not driving leaves the line released
   assign val = claim ? (funcOe ? funcOut : 1'b1) : latchBit;
   assign odMode = ~pushPull | forceOd;
   assign drvVal = val;
   // a silent peripheral releases its pin even when push-pull,
   // otherwise an input function would fight the board driver
   assign released = claim & ~funcOe;
   // open-drain never drives a one; off crossbar means input only
   assign drvOe = xbarOn & ~released & (~odMode | ~val);
   // pull-up only on open-drain pins that are not pulling low
   assign pullOn = ~pullDis & odMode & ~(drvOe & ~val);
endmodule

/* File: tb/pcx_pad_model.sv */
// board-side pad model resolving each pin level for the crossbar
`timescale 1ns/100ps
module pcx_pad_model (
   input wire clk,
   input wire [23:0] pinOut,
   input wire [23:0] pinOe,
   input wire [23:0] pinPullEn,
   input wire [23:0] extEn,
   input wire [23:0] extVal,
   output wire [23:0] pinIn
);
   reg floatQ; // level of a floating pad, flips every cycle
   initial floatQ = 1'h0;
   // a bare pad must not look like it holds its last value
   always @(posedge clk) begin
      floatQ <= ~floatQ;
   end
   wire [23:0] freeW; // pads nobody drives
   assign freeW = ~pinOe & ~extEn;
   // device drive, then board drive, then pull-up, else floating
   assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) |
      (freeW & pinPullEn) | (freeW & ~pinPullEn & {24{floatQ}});
endmodule

/* File: tb/pcx_crossbar_chk.sv */
// concurrent checks on the crossbar ports
`timescale 1ns/100ps
`include "pcx_consts.vh"
module pcx_crossbar_chk #(
   parameter NF = `PCX_NFUNC,
   parameter NP = `PCX_NPIN
) (
   input wire clk,
   input wire sys_rst,
   input wire [7:0] sfrAddr,
   input wire sfrWrEn,
   input wire [7:0] sfrWrData,
   input wire sfrRdEn,
   input wire sfrRmw,
   input wire [7:0] sfrRdData,
   input wire sfrRdHit,
   input wire [NF-1:0] funcOut,
   input wire [NF-1:0] funcOe,
   input wire [NF-1:0] funcIn,
   input wire [NP-1:0] pinIn,
   input wire [NP-1:0] pinOut,
   input wire [NP-1:0] pinOe,
   input wire [NP-1:0] pinPullEn
);
   reg [7:0] r1Q; // shadow of first routing register
   reg [7:0] r3Q; // shadow of third, unused bits dropped
   wire mapped; // address belongs to this block
   wire swOn; // two-wire bus routed
   assign mapped = sfrAddr == `PCX_ADDR_P0LAT || sfrAddr == `PCX_ADDR_P1LAT
      || sfrAddr == `PCX_ADDR_P0CFG || sfrAddr == `PCX_ADDR_P1CFG
      || sfrAddr == `PCX_ADDR_ROUTE1 || sfrAddr == `PCX_ADDR_ROUTE2
      || sfrAddr == `PCX_ADDR_ROUTE3;
   assign swOn = r1Q[0] && r3Q[6];
   // shadows track byte writes; routing registers are not bit-written
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r1Q <= 8'h00;
         r3Q <= 8'h00;
      end else if (sfrWrEn && sfrAddr == `PCX_ADDR_ROUTE1) begin
         r1Q <= sfrWrData;
      end else if (sfrWrEn && sfrAddr == `PCX_ADDR_ROUTE3) begin
         r3Q <= sfrWrData & `PCX_R3_MASK;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_rd1;
      sfrRdEn && sfrAddr == `PCX_ADDR_ROUTE1;
   endsequence
   sequence s_rd3;
      sfrRdEn && sfrAddr == `PCX_ADDR_ROUTE3;
   endsequence
   a_unmapped_read_zero:
      assert property (sfrRdEn && !mapped |=> !sfrRdHit && sfrRdData == 8'h00)
      else $error("unmapped read not empty");
   a_read_data_stands:
      assert property (!sfrRdEn |=> $stable(sfrRdData) && $stable(sfrRdHit))
      else $error("read data moved without a read");
   a_route3_readback:
      assert property (s_rd3 |=> sfrRdHit && sfrRdData == $past(r3Q))
      else $error("third routing register readback wrong");
   a_route1_readback:
      assert property (s_rd1 |=> sfrRdData == $past(r1Q))
      else $error("first routing register readback wrong");
   a_pin_read_levels:
      assert property (sfrRdEn && !sfrRmw && sfrAddr == `PCX_ADDR_P0LAT
         |=> sfrRdData == $past(pinIn[7:0]))
      else $error("port read not pin levels");
   a_no_pull_driven:
      assert property ((pinOe & pinPullEn) == {NP{1'h0}})
      else $error("pull-up on a driven pin");
   a_route_off_quiet:
      assert property (!r3Q[6] |=> pinOe == {NP{1'h0}})
      else $error("pin driven with routing off");
   a_func_in_idle:
      assert property (!r3Q[6] |=> funcIn == {NF{1'h1}})
      else $error("function input not idle with routing off");
   a_two_wire_od:
      assert property (swOn |=> !(pinOe[0] && pinOut[0]) &&
         !(pinOe[1] && pinOut[1]))
      else $error("two-wire pin driven high");
   a_sda_slot_low:
      assert property (swOn && funcOe[0] && !funcOut[0] |=> pinOe[0] && !pinOut[0])
      else $error("data line not on first pin");
   a_sda_in_follow:
      assert property (swOn |=> funcIn[0] == $past(pinIn[0]))
      else $error("data line input not from first pin");
endmodule
bind pcx_crossbar pcx_crossbar_chk #(.NF(NF), .NP(NP)) u_pcx_crossbar_chk (
   .clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
   .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRmw(sfrRmw),
   .sfrRdData(sfrRdData), .sfrRdHit(sfrRdHit), .funcOut(funcOut),
   .funcOe(funcOe), .funcIn(funcIn), .pinIn(pinIn), .pinOut(pinOut),
   .pinOe(pinOe), .pinPullEn(pinPullEn));

/* File: tb/pcx_crossbar_tb_top.sv */
// self-checking bench for the crossbar and port block
`timescale 1ns/100ps
`include "pcx_consts.vh"
module pcx_crossbar_tb_top;
   reg clk = 1'h0; // 200 MHz
   reg sys_rst = 1'h1;
   reg [7:0] sfrAddr = 8'h00;
   reg sfrWrEn = 1'h0;
   reg [7:0] sfrWrData = 8'h00;
   reg sfrBitWrEn = 1'h0;
   reg [2:0] sfrBitSel = 3'h0;
   reg sfrBitVal = 1'h0;
   reg sfrRdEn = 1'h0;
   reg sfrRmw = 1'h0;
   reg [23:0] funcOut = 24'h000000; // peripheral outputs
   reg [23:0] funcOe = 24'h000000;
   reg [23:0] extEn = 24'h000000; // board drivers
   reg [23:0] extVal = 24'h000000;
   wire [7:0] sfrRdData;
   wire sfrRdHit;
   wire [23:0] funcIn, pinIn, pinOut, pinOe, pinPullEn;
   integer err_count = 0;
   integer n_tests = 0;
   integer cycles = 0; // hang guard
   always #2.5 clk = ~clk;
   pcx_crossbar u_pcx_crossbar (.clk(clk), .sys_rst(sys_rst),
      .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
      .sfrBitWrEn(sfrBitWrEn), .sfrBitSel(sfrBitSel), .sfrBitVal(sfrBitVal),
      .sfrRdEn(sfrRdEn), .sfrRmw(sfrRmw), .sfrRdData(sfrRdData),
      .sfrRdHit(sfrRdHit), .funcOut(funcOut), .funcOe(funcOe),
      .funcIn(funcIn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .pinPullEn(pinPullEn));
   pcx_pad_model u_pcx_pad_model (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
      .pinPullEn(pinPullEn), .extEn(extEn), .extVal(extVal), .pinIn(pinIn));
   task results;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // a hung handshake ends the run as a failure
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         results;
      end
   end
   task chk(input string nm, input [23:0] seen, input [23:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // bus strobes rise at one falling edge and drop at the next
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge clk);
         sfrAddr = a;
         sfrWrData = d;
         sfrWrEn = 1'h1;
         @(negedge clk);
         sfrWrEn = 1'h0;
      end
   endtask
   task bitWr(input [7:0] a, input [2:0] s, input v);
      begin
         @(negedge clk);
         sfrAddr = a;
         sfrBitSel = s;
         sfrBitVal = v;
         sfrBitWrEn = 1'h1;
         @(negedge clk);
         sfrBitWrEn = 1'h0;
      end
   endtask
   task rd(input [7:0] a, input m, output [7:0] d);
      begin
         @(negedge clk);
         sfrAddr = a;
         sfrRmw = m;
         sfrRdEn = 1'h1;
         @(negedge clk);
         sfrRdEn = 1'h0;
         d = sfrRdData;
      end
   endtask
   task t_reset;
      reg [55:0] aList;
      reg [7:0] d;
      integer i;
      begin
         aList = 56'h8090A4A5E1E2E3;
         for (i = 0; i < 7; i = i + 1) begin
            rd(aList[55-8*i -: 8], 1'h1, d);
            chk("resetValue", d, (i < 2) ? 24'h0000FF : 24'h000000);
            chk("readHit", sfrRdHit, 24'h000001);
         end
         rd(8'h81, 1'h0, d);
         chk("unmappedData", d, 24'h000000);
         chk("unmappedHit", sfrRdHit, 24'h000000);
         chk("resetOe", pinOe, 24'h000000);
         chk("resetPull", pinPullEn, 24'hFFFFFF);
         wr(`PCX_ADDR_ROUTE3, 8'hFF);
         rd(`PCX_ADDR_ROUTE3, 1'h0, d);
         chk("route3Mask", d, 24'h0000C1);
         wr(`PCX_ADDR_ROUTE3, 8'h00);
         $display("test reset done");
      end
   endtask
   task t_ports;
      reg [7:0] d;
      begin
         wr(`PCX_ADDR_P0CFG, 8'hFF); // push-pull keeps pads defined
         wr(`PCX_ADDR_P0LAT, 8'h00);
         repeat (2) @(negedge clk);
         chk("offOe", pinOe, 24'h000000);
         wr(`PCX_ADDR_ROUTE3, 8'h40);
         wr(`PCX_ADDR_P1CFG, 8'hFF);
         wr(`PCX_ADDR_P1LAT, 8'hA5);
         repeat (2) @(negedge clk);
         chk("p0Oe", pinOe[7:0], 24'h0000FF);
         chk("p1Out", pinOut[15:8], 24'h0000A5);
         chk("p1PpPull", pinPullEn[15:8], 24'h000000);
         wr(`PCX_ADDR_P1CFG, 8'h00);
         repeat (2) @(negedge clk);
         chk("p1OdOe", pinOe[15:8], 24'h00005A);
         chk("p1OdPull", pinPullEn[15:8], 24'h0000A5);
         rd(`PCX_ADDR_P1LAT, 1'h0, d);
         chk("p1Pins", d, 24'h0000A5);
         wr(`PCX_ADDR_ROUTE3, 8'hC0);
         repeat (2) @(negedge clk);
         chk("pullOff", pinPullEn, 24'h000000);
         wr(`PCX_ADDR_ROUTE3, 8'h40);
         wr(`PCX_ADDR_P0CFG, 8'h00);
         wr(`PCX_ADDR_P0LAT, 8'hFF);
         extEn = 24'h000008;
         repeat (2) @(negedge clk);
         rd(`PCX_ADDR_P0LAT, 1'h0, d);
         chk("p0Pins", d, 24'h0000F7);
         rd(`PCX_ADDR_P0LAT, 1'h1, d);
         chk("p0Latch", d, 24'h0000FF);
         bitWr(`PCX_ADDR_P0LAT, 3'h3, 1'h0);
         rd(`PCX_ADDR_P0LAT, 1'h1, d);
         chk("p0BitWr", d, 24'h0000F7);
         chk("p0BitOe", pinOe[7:0], 24'h000008);
         extEn = 24'h000000;
         $display("test ports done");
      end
   endtask
   task t_caps;
      integer c;
      integer n;
      begin
         wr(`PCX_ADDR_P0CFG, 8'hFF);
         wr(`PCX_ADDR_P0LAT, 8'h00);
         funcOe = 24'hFFFFFF;
         funcOut = 24'h001F00;
         for (c = 0; c < 8; c = c + 1) begin
            n = (c > 5) ? 0 : c;
            wr(`PCX_ADDR_ROUTE1, {2'h0, c[2:0], 3'h1});
            repeat (2) @(negedge clk);
            chk("capPins", pinOut[7:0], 24'(((1 << n) - 1) << 2));
            chk("twoWireOe", pinOe[1:0], 24'h000003);
         end
         funcOut = 24'hFFFFFF;
         wr(`PCX_ADDR_ROUTE1, 8'h06);
         repeat (2) @(negedge clk);
         chk("spiUartOe", pinOe[6:0], 24'h00005F);
         chk("spiUartOut", pinOut[4:0], 24'h00001F);
         wr(`PCX_ADDR_ROUTE1, 8'h04);
         repeat (2) @(negedge clk);
         chk("uartOe", pinOe[2:0], 24'h000005);
         $display("test caps and serial done");
      end
   endtask
   task t_single;
      integer k;
      integer idx;
      begin
         funcOe = 24'h000000;
         extEn = 24'h000001;
         for (k = 0; k < 11; k = k + 1) begin
            idx = (k < 8) ? 15 + k : (k == 8) ? 14 : (k == 9) ? 13 : 23;
            wr(`PCX_ADDR_ROUTE1, (k == 8) ? 8'h80 : (k == 9) ? 8'h40 : 8'h00);
            wr(`PCX_ADDR_ROUTE2, (k < 8) ? 8'(1 << k) : 8'h00);
            wr(`PCX_ADDR_ROUTE3, (k == 10) ? 8'h41 : 8'h40);
            repeat (2) @(negedge clk);
            chk("singleIn", funcIn, ~(24'h000001 << idx));
            chk("singleOe", pinOe[0], 24'h000000);
         end
         $display("test single routes done");
      end
   endtask
   initial begin
      repeat (20) @(negedge clk);
      sys_rst = 1'h0;
      t_reset;
      t_ports;
      t_caps;
      t_single;
      results;
   end
endmodule
